// [src/meter_irq_pkg.sv]
// Constants shared by the interrupt flag logic of the metering core.
// Assumes register addresses come from the serial interface logic; the flag logic decodes the offsets.
package meter_irq_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFFS_FLAGS       = 8'h04; // Status, read only
    localparam logic [7:0] OFFS_FLAGS_CLEAR = 8'h05; // Status, clear on read
    localparam logic [7:0] OFFS_MASK        = 8'h1E; // Enable register
    // ****************************************
    // Field positions, shared by all three registers
    // ****************************************
    localparam int NUM_FLAGS       = 8;
    localparam int BIT_HALF_FULL   = 0;
    localparam int BIT_SAG         = 1;
    localparam int BIT_CYCLE_DONE  = 2;
    localparam int BIT_WAVE_SAMPLE = 3;
    localparam int BIT_ZERO_CROSS  = 4;
    localparam int BIT_TEMP_READY  = 5;
    localparam int BIT_RESET_DONE  = 6;
    localparam int BIT_OVERFLOW    = 7;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] FLAGS_RESET = 8'h00; // Latched flags after reset
    localparam logic [7:0] MASK_RESET  = 8'h00; // All sources masked
    localparam logic [7:0] NO_IRQ_MASK = 8'hBF; // Reset-done never interrupts
    localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage

// [src/sticky_flag.sv]
// One sticky interrupt flag with set-over-clear priority.
// Assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic set,
    input  wire logic clr,
    // State
    output logic      q
);
    // ****************************************
    // Flag storage
    // ****************************************
    // Set wins so an event during a clear is not lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [src/meter_interrupt_flags.sv]
// Interrupt status, clear-on-read status and enable logic of the meter.
// Assumes event inputs come from datapath logic on clk, and register
// accesses are single-cycle strobes from the serial interface.
// Event inputs are same-clock logic, so no synchronisers sit on them.
//
// Operation
// - Internal event sets its status flag high
// - Enabled set flag drives request output low
// - Bit 0: energy MSB rises 0 to 1
// - Bit 1: voltage dip or missing crossings
// - Bit 2: line-cycle accumulation finished
// - Bit 3: new waveform sample written
// - Bit 4 follows live zero-cross output
// - Bit 5: temperature result ready
// - Bit 6 set after reset, never interrupts
// - Bit 7: active energy register overflowed
// - Status, clear and enable share layout
`timescale 1ns/1ps
`default_nettype none
module meter_interrupt_flags #(
    parameter int FLAG_COUNT = meter_irq_pkg::NUM_FLAGS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Software reset strobe from the mode register
    input  wire logic                  soft_reset,
    // Event sources
    input  wire logic                  energy_msb,
    input  wire logic                  energy_overflow,
    input  wire logic                  sag_event,
    input  wire logic                  line_cycle_done,
    input  wire logic                  waveform_sample,
    input  wire logic                  zero_cross,
    input  wire logic                  temp_ready,
    // Register access
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [FLAG_COUNT-1:0] reg_wdata,
    output logic      [FLAG_COUNT-1:0] reg_rdata,
    // Open-drain request pin
    output logic                       irq_out,
    output logic                       irq_oe_n
);
    // ****************************************
    // Internal signals
    // ****************************************
    logic                  msb_prev;       // Energy MSB last cycle
    logic                  reset_end;      // End-of-reset strobe
    logic                  soft_pending;   // Soft reset seen last cycle
    logic                  started;        // First cycle after release done
    logic [FLAG_COUNT-1:0] set_vec;        // Per-bit set strobes
    logic [FLAG_COUNT-1:0] latched;        // Sticky flags
    logic [FLAG_COUNT-1:0] status;         // Visible status word
    logic [FLAG_COUNT-1:0] interrupt_mask; // Enable register
    logic                  clr_all;        // Clear strobe
    logic                  next_irq;       // Request wanted

    // Register address match, used for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
        hit = (a == offs);
    endfunction

    // ****************************************
    // Event conditioning
    // ****************************************
    // Previous MSB for rising edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msb_prev <= 1'b0;
        end else begin
            msb_prev <= energy_msb;
        end
    end

    // End of hardware reset: one strobe on first cycle after release
    // Reads as zero only until the first edge after release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // End of software reset: strobe one cycle after the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_pending <= 1'b0;
        end else begin
            soft_pending <= soft_reset;
        end
    end

    // Reset-done set by either source; hardware case is the first cycle
    assign reset_end = !started || soft_pending;

    // Map each source onto its bit
    always_comb begin
        // Bit 4 stays zero here: it is shown live, never latched
        set_vec                              = '0;
        set_vec[meter_irq_pkg::BIT_HALF_FULL]   = energy_msb && !msb_prev;
        set_vec[meter_irq_pkg::BIT_SAG]         = sag_event;
        set_vec[meter_irq_pkg::BIT_CYCLE_DONE]  = line_cycle_done;
        set_vec[meter_irq_pkg::BIT_WAVE_SAMPLE] = waveform_sample;
        set_vec[meter_irq_pkg::BIT_TEMP_READY]  = temp_ready;
        set_vec[meter_irq_pkg::BIT_RESET_DONE]  = reset_end;
        set_vec[meter_irq_pkg::BIT_OVERFLOW]    = energy_overflow;
    end

    // ****************************************
    // Flag storage
    // ****************************************
    // Clear on read of the clear register, or by soft reset
    // Soft reset shares this clear so both paths empty the flags alike
    assign clr_all = soft_reset
                  || (reg_rd && hit(reg_addr, meter_irq_pkg::OFFS_FLAGS_CLEAR));

    // One sticky flag per latched source; zero-cross is live
    // Set-over-clear sits in the flag cell so no event is dropped
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
            if (gi == meter_irq_pkg::BIT_ZERO_CROSS) begin : g_live
                // Live bit: no storage, so a clear cannot touch it
                assign latched[gi] = 1'b0;
                assign status[gi]  = zero_cross;
            end else begin : g_sticky
                // Latched bit: set by its event, emptied by a clear
                sticky_flag u_flag (
                    .clk     (clk),
                    .reset_n (reset_n),
                    .set     (set_vec[gi]),
                    .clr     (clr_all),
                    .q       (latched[gi])
                );
                assign status[gi] = latched[gi];
            end
        end
    endgenerate

    // ****************************************
    // Enable register
    // ****************************************
    // Same layout as status; bit 6 stored but gated off later
    // Soft reset masks every source again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_mask <= meter_irq_pkg::MASK_RESET;
        end else if (soft_reset) begin
            interrupt_mask <= meter_irq_pkg::MASK_RESET;
        end else if (reg_wr && hit(reg_addr, meter_irq_pkg::OFFS_MASK)) begin
            interrupt_mask <= reg_wdata;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Registered read; unmapped addresses read zero
    // Status and clear offsets return the same word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= meter_irq_pkg::RDATA_RESET;
        end else if (reg_rd) begin
            if (hit(reg_addr, meter_irq_pkg::OFFS_FLAGS)
                || hit(reg_addr, meter_irq_pkg::OFFS_FLAGS_CLEAR)) begin
                reg_rdata <= status;
            end else if (hit(reg_addr, meter_irq_pkg::OFFS_MASK)) begin
                reg_rdata <= interrupt_mask;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    // ****************************************
    // Request pin
    // ****************************************
    // Any enabled flag except reset-done asks for service
    // Bit 6 is cut by a constant mask, so its enable does nothing
    assign next_irq = |(status & interrupt_mask & meter_irq_pkg::NO_IRQ_MASK);

    // Enable low drives the wire low; held while a flag stands
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_oe_n <= 1'b1;
        end else begin
            irq_oe_n <= !next_irq;
        end
    end

    // Open-drain data is always low
    // Only the enable moves, as an open-drain pin needs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= 1'b0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Energy MSB rise latches the half-full flag
    a_half_full_edge: assert property (@(posedge clk) disable iff (!reset_n)
        (energy_msb && !msb_prev) |=> latched[meter_irq_pkg::BIT_HALF_FULL])
        else $error("half-full flag not set on MSB rise");
    // Overflow pulse latches its flag
    a_overflow_set: assert property (@(posedge clk) disable iff (!reset_n)
        energy_overflow |=> latched[meter_irq_pkg::BIT_OVERFLOW])
        else $error("overflow flag not set");
    // Each remaining pulsed source latches its own bit one edge later
    a_sag_set: assert property (@(posedge clk) disable iff (!reset_n)
        sag_event |=> latched[meter_irq_pkg::BIT_SAG])
        else $error("dip flag not set");
    a_cycle_done_set: assert property (@(posedge clk) disable iff (!reset_n)
        line_cycle_done |=> latched[meter_irq_pkg::BIT_CYCLE_DONE])
        else $error("line-cycle flag not set");
    a_wave_sample_set: assert property (@(posedge clk) disable iff (!reset_n)
        waveform_sample |=> latched[meter_irq_pkg::BIT_WAVE_SAMPLE])
        else $error("sample flag not set");
    a_temp_ready_set: assert property (@(posedge clk) disable iff (!reset_n)
        temp_ready |=> latched[meter_irq_pkg::BIT_TEMP_READY])
        else $error("temperature flag not set");

    // An event in the cycle of a clear must survive it
    a_set_wins_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (clr_all && waveform_sample) |=> latched[meter_irq_pkg::BIT_WAVE_SAMPLE])
        else $error("sample event lost during clear");
    // Without a clear, flags only gather new events
    a_flags_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (reset_n && !clr_all)
        |=> latched == ($past(latched) | $past(set_vec)))
        else $error("flag changed without event or clear");

    // Request follows enabled flags, reset-done excluded
    a_irq_enabled_flag: assert property (@(posedge clk) disable iff (!reset_n)
        (|(latched & interrupt_mask & meter_irq_pkg::NO_IRQ_MASK)) |=> !irq_oe_n)
        else $error("request not driven for enabled flag");
    a_reset_flag_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        ((status & meter_irq_pkg::NO_IRQ_MASK) == '0) |=> irq_oe_n)
        else $error("reset-done flag drove request");

    // Reset-done flag appears after either kind of reset
    a_soft_reset_flag: assert property (@(posedge clk) disable iff (!reset_n)
        soft_reset |=> ##1 latched[meter_irq_pkg::BIT_RESET_DONE])
        else $error("reset-done flag missing after soft reset");
    a_reset_done_hw: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(started) |-> latched[meter_irq_pkg::BIT_RESET_DONE])
        else $error("reset-done flag missing after reset");

    // Status reads: clear register empties, live bit follows input
    a_clear_read_flags: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && hit(reg_addr, meter_irq_pkg::OFFS_FLAGS_CLEAR) && set_vec == '0)
        |=> (latched == '0) && (reg_rdata == $past(status)))
        else $error("clear read wrong");
    a_zero_cross_live: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && hit(reg_addr, meter_irq_pkg::OFFS_FLAGS))
        |=> reg_rdata[meter_irq_pkg::BIT_ZERO_CROSS] == $past(zero_cross))
        else $error("zero-cross bit not live");

    // Enable register writes and reads back; holes read zero
    a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_wr && !soft_reset && hit(reg_addr, meter_irq_pkg::OFFS_MASK))
        |=> interrupt_mask == $past(reg_wdata))
        else $error("enable write not stored");
    a_mask_read: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && hit(reg_addr, meter_irq_pkg::OFFS_MASK))
        |=> reg_rdata == $past(interrupt_mask))
        else $error("enable read-back wrong");
    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && !hit(reg_addr, meter_irq_pkg::OFFS_FLAGS)
            && !hit(reg_addr, meter_irq_pkg::OFFS_FLAGS_CLEAR)
            && !hit(reg_addr, meter_irq_pkg::OFFS_MASK))
        |=> reg_rdata == '0)
        else $error("unmapped read not zero");

    // Request lets go one edge after the last enabled flag
    a_irq_release: assert property (@(posedge clk) disable iff (!reset_n)
        (!irq_oe_n && !next_irq) |=> irq_oe_n)
        else $error("request held after flags gone");

    // ****************************************
    // Cover points
    // ****************************************
    // Request raised from idle
    c_irq_raised: cover property (@(posedge clk) disable iff (!reset_n)
        irq_oe_n ##1 !irq_oe_n);
    // Clear read while a request stands
    c_clear_read: cover property (@(posedge clk) disable iff (!reset_n)
        !irq_oe_n && reg_rd && hit(reg_addr, meter_irq_pkg::OFFS_FLAGS_CLEAR));
    c_soft_reset: cover property (@(posedge clk) disable iff (!reset_n)
        soft_reset ##2 latched[meter_irq_pkg::BIT_RESET_DONE]);
    // Event and clear in one cycle
    c_set_over_clear: cover property (@(posedge clk) disable iff (!reset_n)
        clr_all && waveform_sample);
    // End of a hardware reset
    c_hw_reset_done: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(started));
endmodule
`default_nettype wire

// [testbench/host_mcu.sv]
// Host model: register strobes and the request pin.
// Assumes one clock shared with the flag block.
`timescale 1ns/1ps
`default_nettype none
module host_mcu (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // Open-drain request
    input  wire logic       irq_out,
    input  wire logic       irq_oe_n,
    output logic            irq_pin_n
);
    // Pull-up holds the pin high when released
    assign irq_pin_n = irq_oe_n ? 1'b1 : irq_out;
    // Idle strobes from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One read; data taken after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Service: status first, then clear-on-read
    task automatic service(output logic [7:0] s, output logic [7:0] c);
        rd(8'h04, s);
        rd(8'h05, c);
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench of the interrupt flag block.
// Assumes the host model drives all register strobes.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk;
    logic       reset_n;
    logic       soft_reset;
    logic [7:0] ev;         // Event inputs by flag position
    logic [7:0] d;
    logic [7:0] c;
    wire  [7:0] addr, wdata, rdata;
    wire        wr, rd, oq, oe_n, irq_n;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    meter_interrupt_flags u_dut (.clk(clk), .reset_n(reset_n), .soft_reset(soft_reset),
        .energy_msb(ev[0]), .energy_overflow(ev[7]), .sag_event(ev[1]),
        .line_cycle_done(ev[2]), .waveform_sample(ev[3]), .zero_cross(ev[4]),
        .temp_ready(ev[5]), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .irq_out(oq), .irq_oe_n(oe_n));
    host_mcu u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .irq_out(oq), .irq_oe_n(oe_n),
        .irq_pin_n(irq_n));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    // Bounded wait for the pin level
    task automatic wait_irq(input logic lvl);
        for (int k = 0; k < 8 && irq_n !== lvl; k++) @(posedge clk);
        #1 chk({7'h00, irq_n}, {7'h00, lvl});
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        u_host.rd(8'h04, d);
        chk(d, 8'h40);
        u_host.rd(8'h1E, d);
        chk(d, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_events();
        u_host.rd(8'h05, d);
        for (int i = 0; i < 8; i++) if (i != 4 && i != 6) begin
            pulse(i);
            u_host.service(d, c);
            chk(d, 8'h01 << i);
            chk(c, 8'h01 << i);
        end
        $display("test events done");
    endtask
    task automatic t_irq();
        pulse(5);
        repeat (3) @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        u_host.wr(8'h1E, 8'h20);
        wait_irq(1'b0);
        repeat (6) @(posedge clk);
        u_host.service(d, c);
        chk({7'h00, irq_n}, 8'h00);
        chk(d, 8'h20);
        chk(c, 8'h20);
        wait_irq(1'b1);
        $display("test irq done");
    endtask
    task automatic t_soft();
        u_host.wr(8'h1E, 8'hFF);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        repeat (3) @(posedge clk);
        u_host.rd(8'h04, d);
        chk(d, 8'h40);
        u_host.wr(8'h1E, 8'h40);
        repeat (4) @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        u_host.rd(8'h05, d);
        $display("test soft reset done");
    endtask
    task automatic t_zero();
        @(posedge clk);
        ev[4] <= 1'b1;
        u_host.service(d, c);
        chk(c, 8'h10);
        u_host.rd(8'h04, d);
        chk(d, 8'h10);
        @(posedge clk);
        ev[4] <= 1'b0;
        u_host.rd(8'h04, d);
        chk(d, 8'h00);
        $display("test zero cross done");
    endtask
    task automatic t_refuse();
        u_host.wr(8'h04, 8'hFF);
        u_host.rd(8'h04, d);
        chk(d, 8'h00);
        u_host.rd(8'h33, d);
        chk(d, 8'h00);
        u_host.wr(8'h1E, 8'h5A);
        u_host.rd(8'h1E, d);
        chk(d, 8'h5A);
        $display("test refuse done");
    endtask
    // Sample event in the very cycle of a clear read must survive it
    task automatic t_race();
        fork
            u_host.rd(8'h05, c);
            pulse(3);
        join
        chk(c, 8'h00);
        u_host.rd(8'h04, d);
        chk(d, 8'h08);
        chk({7'h00, irq_n}, 8'h00);
        u_host.rd(8'h05, d);
        $display("test set over clear done");
    endtask
    // Hardware reset in mid-run drops request and mask, sets reset-done
    task automatic t_hw_reset();
        u_host.wr(8'h1E, 8'hFF);
        pulse(7);
        wait_irq(1'b0);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        u_host.rd(8'h04, d);
        chk(d, 8'h40);
        u_host.rd(8'h1E, d);
        chk(d, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        u_host.rd(8'h05, d);
        $display("test hardware reset done");
    endtask
    // ****************************************
    // Clock, timeout, sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        reset_n = 1'b0;
        soft_reset = 1'b0;
        ev = 8'h00;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_events();
        t_irq();
        t_soft();
        t_zero();
        t_refuse();
        t_race();
        t_hw_reset();
        test_done();
    end
endmodule
`default_nettype wire
